// ---- rtl/hall_ctrl_map.vh ----
// Constants for the Hall sensor option and conversion controller
`ifndef HALL_CTRL_MAP_VH
`define HALL_CTRL_MAP_VH

`define CLK_PERIOD_NS      8
`define WORD_BITS          16
`define WORD_GAP_NS        100
`define WORD_GAP_CYC       ((`WORD_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define GAIN_100MT         2'h0
`define GAIN_300MT         2'h1
`define GAIN_1T            2'h2
`define GAIN_3T            2'h3

`define AXIS_SCAN          2'h0
`define AXIS_X             2'h1
`define AXIS_Y             2'h2
`define AXIS_Z             2'h3

`define RATE_3K_HZ         3000
`define RATE_375_HZ        375
`define CONV_3K_CYC        (125000000 / `RATE_3K_HZ)
`define CONV_1K5_CYC       (125000000 / 1500)
`define CONV_750_CYC       (125000000 / 750)
`define CONV_375_CYC       (125000000 / `RATE_375_HZ)

`define BITS_14            5'h0E
`define BITS_15            5'h0F
`define BITS_16            5'h10

`define BOOST_NUM          13
`define BOOST_DEN          10

`define CH_X               2'h0
`define CH_Y               2'h1
`define CH_Z               2'h2
`define CH_T               2'h3

`define FIFO_DEPTH         16
`define FIFO_AW            4
`endif

// ---- rtl/sample_fifo.v ----
// Synchronous FIFO carrying finished samples to the serial port
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             core_clk_i, // Core clock
    input  wire             rst_n_i,    // Synchronous reset, active low
    input  wire             clk_en_i,   // Freezes all state when low
    input  wire             flush_i,    // Drops all content
    input  wire [WIDTH-1:0] in_data_i,  // Write data
    input  wire             in_valid_i, // Write request
    output wire             in_ready_o, // Not full
    output reg  [WIDTH-1:0] out_data_o, // Head word
    output wire             out_valid_o,// Not empty
    input  wire             out_ready_i // Head taken
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_q;
    reg [AW:0]      rd_q;
    wire            full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire            empty = (wr_q == rd_q);
    wire            push  = in_valid_i && !full;
    wire            pop   = out_valid_o && out_ready_i;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;

    always @* begin
        out_data_o = mem[rd_q[AW-1:0]];
    end

    always @(posedge core_clk_i) begin
        if (!rst_n_i || (clk_en_i && flush_i)) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else if (clk_en_i) begin
            if (push) begin
                mem[wr_q[AW-1:0]] <= in_data_i;
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/hall_ctrl.v ----
// Option decode, conversion sequencing and SPI mode 0 slave of the Hall sensor
`timescale 1ns/1ns
`default_nettype none
`include "hall_ctrl_map.vh"
module hall_ctrl (
    input  wire        core_clk_i,         // 125 MHz core clock
    input  wire        rst_n_i,            // Synchronous reset, active low
    input  wire        clk_en_i,           // Freezes all state when low
    input  wire        interface_select_i, // High selects analog mode
    input  wire [1:0]  gain_sel_i,         // Range pins
    input  wire [1:0]  axis_choice_i,      // Axis pins
    input  wire        low_power_i,        // Low power pin
    input  wire        polarity_flip_i,    // Bias reversal pin
    input  wire        range_boost_i,      // Range widening pin
    input  wire [1:0]  conv_rate_sel_i,    // 0: 3 kHz ... 3: 0.375 kHz
    input  wire [1:0]  out_channel_i,      // Channel reported on the port
    input  wire        ready_on_miso_i,    // Ready copied to miso_o while idle; miso_oe_o stays low
    input  wire        conv_hold_i,        // Converter hold pin
    input  wire [15:0] adc_x_i,            // Raw 16-bit converter results
    input  wire [15:0] adc_y_i,            // Y result
    input  wire [15:0] adc_z_i,            // Z result
    input  wire [15:0] adc_t_i,            // Temperature result
    input  wire        sclk_i,             // SPI clock from master
    input  wire        cs_n_i,             // SPI chip select, active low
    input  wire        mosi_i,             // SPI data in
    output reg         miso_o,             // SPI data out
    output reg         miso_oe_o,          // MISO driven when high
    output reg         sample_ready_flag_o,// Data ready pin
    output reg  [15:0] rx_word_o,          // Last word from master
    output reg         rx_valid_o,         // One-cycle pulse per word
    output reg  [1:0]  gain_o,             // Decoded range to amplifier
    output reg         boost_o,            // Range widened by 30 percent
    output reg  [2:0]  axis_en_o,          // Amplified axes, z y x
    output reg         scan_o,             // Axis multiplexer running
    output reg         low_power_o,        // Low power bias
    output reg         bias_flip_o,        // Hall bias reversed
    output reg  [4:0]  out_bits_o,         // Bits delivered
    output reg         conv_run_o,         // Converters running
    output reg  [3:0]  conv_strobe_o,      // Per converter end pulse t z y x
    output reg  [1:0]  mux_axis_o          // Axis now on shared amplifier
);
    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    // Pins idle low, matching pull-downs, so a floating pin decodes as 0
    reg [10:0] pin_s1_q;
    reg [10:0] pin_s2_q;
    reg [2:0]  spi_s1_q;
    reg [2:0]  spi_s2_q;
    reg [2:0]  spi_s3_q;
    wire [10:0] pins = {interface_select_i, gain_sel_i, axis_choice_i, low_power_i,
                        polarity_flip_i, range_boost_i, conv_rate_sel_i, conv_hold_i};

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= 11'h000;
            pin_s2_q <= 11'h000;
            spi_s1_q <= 3'h1;
            spi_s2_q <= 3'h1;
            spi_s3_q <= 3'h1;
        end else if (clk_en_i) begin
            pin_s1_q <= pins;
            pin_s2_q <= pin_s1_q;
            spi_s1_q <= {sclk_i, mosi_i, cs_n_i};
            spi_s2_q <= spi_s1_q;
            spi_s3_q <= spi_s2_q;
        end
    end

    wire       analog_s = pin_s2_q[10];
    wire [1:0] gain_s   = pin_s2_q[9:8];
    wire [1:0] axis_s   = pin_s2_q[7:6];
    wire       lp_s     = pin_s2_q[5];
    wire       flip_s   = pin_s2_q[4];
    wire       boost_s  = pin_s2_q[3];
    wire [1:0] rate_s   = pin_s2_q[2:1];
    wire       hold_s   = pin_s2_q[0];
    wire       sclk_s   = spi_s2_q[2];
    wire       mosi_s   = spi_s2_q[1];
    wire       cs_s     = spi_s2_q[0];
    wire       sclk_rise = sclk_s && !spi_s3_q[2];
    wire       sclk_fall = !sclk_s && spi_s3_q[2];
    wire       cs_fall   = !cs_s && spi_s3_q[0];

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function [31:0] period_of;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    period_of = `CONV_3K_CYC;
                2'h1:    period_of = `CONV_1K5_CYC;
                2'h2:    period_of = `CONV_750_CYC;
                default: period_of = `CONV_375_CYC;
            endcase
        end
    endfunction

    function [4:0] bits_of;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    bits_of = `BITS_14;
                2'h1:    bits_of = `BITS_15;
                default: bits_of = `BITS_16;
            endcase
        end
    endfunction

    // Drop low bits to the delivered width and invert about mid-scale
    function [15:0] scale;
        input [15:0] raw;
        input [4:0]  bits;
        input        flip;
        reg   [15:0] v;
        begin
            v = flip ? (16'hFFFF - raw) : raw;
            if (bits == `BITS_14)
                scale = {2'h0, v[15:2]};
            else if (bits == `BITS_15)
                scale = {1'h0, v[15:1]};
            else
                scale = v;
        end
    endfunction

    // ----------------------------------------------------------------
    // Option decode
    // ----------------------------------------------------------------
    // Options other than the rate come from pins only in analog mode; digital mode keeps their defaults
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            gain_o      <= `GAIN_100MT;
            boost_o     <= 1'b0;
            axis_en_o   <= 3'h7;
            scan_o      <= 1'b1;
            low_power_o <= 1'b0;
            bias_flip_o <= 1'b0;
            out_bits_o  <= `BITS_14;
        end else if (clk_en_i) begin
            gain_o      <= analog_s ? gain_s : `GAIN_100MT;
            boost_o     <= analog_s && boost_s;
            low_power_o <= analog_s && lp_s;
            bias_flip_o <= analog_s && flip_s;
            scan_o      <= !analog_s || (axis_s == `AXIS_SCAN);
            case (analog_s ? axis_s : `AXIS_SCAN)
                `AXIS_X: axis_en_o <= 3'h1;
                `AXIS_Y: axis_en_o <= 3'h2;
                `AXIS_Z: axis_en_o <= 3'h4;
                default: axis_en_o <= 3'h7;
            endcase
            out_bits_o  <= bits_of(rate_s);
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencing
    // ----------------------------------------------------------------
    reg [31:0] conv_cnt_q;
    reg        hold_q;
    wire [31:0] period = period_of(rate_s);
    wire        conv_end = conv_run_o && (conv_cnt_q >= period - 32'h1);
    wire        restart  = hold_q && !hold_s;

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            conv_cnt_q    <= 32'h0;
            hold_q        <= 1'b0;
            conv_run_o    <= 1'b0;
            conv_strobe_o <= 4'h0;
            mux_axis_o    <= `CH_X;
        end else if (clk_en_i) begin
            hold_q        <= hold_s;
            conv_strobe_o <= 4'h0;
            if (hold_s) begin
                conv_run_o <= 1'b0;
                conv_cnt_q <= 32'h0;
            end else begin
                conv_run_o <= 1'b1;
                conv_cnt_q <= (conv_end || restart) ? 32'h0 : conv_cnt_q + 32'h1;
                // The temperature converter and each enabled axis converter finish together at the shared rate
                if (conv_end)
                    conv_strobe_o <= {1'b1, axis_en_o};
            end
            // Shared amplifier walks the axes; parked when one is chosen
            if (scan_o)
                mux_axis_o <= (mux_axis_o == `CH_Z) ? `CH_X : mux_axis_o + 2'h1;
            else
                mux_axis_o <= axis_en_o[2] ? `CH_Z : (axis_en_o[1] ? `CH_Y : `CH_X);
        end
    end

    // ----------------------------------------------------------------
    // Sample buffer
    // ----------------------------------------------------------------
    reg  [15:0] sel_raw;
    wire [15:0] fifo_out;
    wire        fifo_valid;
    wire        fifo_ready;
    reg         fifo_take;
    wire        sel_end = conv_strobe_o[out_channel_i];

    always @* begin
        case (out_channel_i)
            `CH_X:   sel_raw = axis_en_o[0] ? adc_x_i : 16'h8000;
            `CH_Y:   sel_raw = axis_en_o[1] ? adc_y_i : 16'h8000;
            `CH_Z:   sel_raw = axis_en_o[2] ? adc_z_i : 16'h8000;
            default: sel_raw = adc_t_i;
        endcase
    end

    // A full buffer drops the newest sample; the master is simply too slow
    sample_fifo #(
        .WIDTH (16),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .clk_en_i    (clk_en_i),
        .flush_i     (hold_s),
        .in_data_i   (scale(sel_raw, out_bits_o, bias_flip_o)),
        .in_valid_i  (sel_end),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take)
    );

    // ----------------------------------------------------------------
    // SPI mode 0 slave
    // ----------------------------------------------------------------
    reg [15:0] tx_q;
    reg [15:0] rx_q;
    reg [4:0]  bit_q;
    reg [15:0] last_q;

    always @* begin
        fifo_take = cs_fall && fifo_valid;
    end

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_q                <= 16'h0000;
            rx_q                <= 16'h0000;
            bit_q               <= 5'h00;
            last_q              <= 16'h0000;
            miso_o              <= 1'b0;
            miso_oe_o           <= 1'b0;
            sample_ready_flag_o <= 1'b0;
            rx_word_o           <= 16'h0000;
            rx_valid_o          <= 1'b0;
        end else if (clk_en_i) begin
            rx_valid_o <= 1'b0;
            miso_oe_o  <= !cs_s || ready_on_miso_i;
            if (cs_s)
                miso_oe_o <= 1'b0;
            // New data raises ready; a frame start clears it, clear wins
            if (fifo_valid && !cs_fall)
                sample_ready_flag_o <= 1'b1;
            else if (cs_fall)
                sample_ready_flag_o <= 1'b0;
            if (cs_fall) begin
                // With no fresh sample the previous one is read again
                tx_q   <= fifo_valid ? fifo_out : last_q;
                last_q <= fifo_valid ? fifo_out : last_q;
                miso_o <= fifo_valid ? fifo_out[15] : last_q[15];
                bit_q  <= 5'h00;
            end else if (!cs_s && sclk_rise) begin
                rx_q  <= {rx_q[14:0], mosi_s};
                bit_q <= bit_q + 5'h01;
                if (bit_q == 5'h0F) begin
                    rx_word_o  <= {rx_q[14:0], mosi_s};
                    rx_valid_o <= 1'b1;
                end
            end else if (!cs_s && sclk_fall) begin
                tx_q   <= {tx_q[14:0], 1'b0};
                miso_o <= tx_q[14];
            end else if (cs_s) begin
                miso_o <= sample_ready_flag_o && ready_on_miso_i;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/hall_ctrl_chk.sv ----
// Concurrent checks on the Hall sensor controller ports
`timescale 1ns/1ns
`default_nettype none
`include "hall_ctrl_map.vh"
module hall_ctrl_chk (
    input wire logic       core_clk_i,         // Clock
    input wire logic       rst_n_i,            // Reset
    input wire logic       interface_select_i, // Mode
    input wire logic [1:0] gain_sel_i,         // Range pins
    input wire logic [1:0] axis_choice_i,      // Axis pins
    input wire logic       low_power_i,        // Low power
    input wire logic       polarity_flip_i,    // Bias flip
    input wire logic       range_boost_i,      // Boost
    input wire logic [1:0] conv_rate_sel_i,    // Rate
    input wire logic       conv_hold_i,        // Hold
    input wire logic       cs_n_i,             // Select
    input wire logic       miso_oe_o,          // MISO enable
    input wire logic       sample_ready_flag_o,// Ready
    input wire logic [1:0] gain_o,             // Range out
    input wire logic       boost_o,            // Boost out
    input wire logic [2:0] axis_en_o,          // Axis enables
    input wire logic       scan_o,             // Scanning
    input wire logic       low_power_o,        // Low power out
    input wire logic       bias_flip_o,        // Flip out
    input wire logic [4:0] out_bits_o,         // Bits
    input wire logic       conv_run_o,         // Running
    input wire logic [3:0] conv_strobe_o       // Ends
);
    wire logic       strobe_any = |conv_strobe_o;
    wire logic [4:0] bits_exp = (conv_rate_sel_i == 2'h0) ? `BITS_14 :
                                (conv_rate_sel_i == 2'h1) ? `BITS_15 : `BITS_16;
    wire logic [2:0] axis_exp = (axis_choice_i == 2'h0) ? 3'h7 : 3'h1 << (axis_choice_i - 2'h1);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Five cycles cover the two-flop synchroniser plus the output register
    a_miso_float_idle: assert property (cs_n_i [*5] |-> !miso_oe_o)
        else $error("MISO driven while deselected");
    a_ready_clear_cs: assert property ($fell(cs_n_i) |-> ##[1:5] !sample_ready_flag_o)
        else $error("ready not cleared at frame start");
    a_ready_after_conv: assert property ($rose(sample_ready_flag_o) |->
        $past(strobe_any, 1) || $past(strobe_any, 2) || $past(strobe_any, 3))
        else $error("ready rose without a conversion end");
    a_hold_no_strobe: assert property ((!conv_run_o) [*2] |-> conv_strobe_o == 4'h0)
        else $error("conversion end while halted");
    a_hold_halts: assert property (conv_hold_i [*5] |-> !conv_run_o)
        else $error("converters run under hold");
    a_bits_follow_rate: assert property ($stable(conv_rate_sel_i) [*5] |->
        out_bits_o == bits_exp)
        else $error("bit count does not follow rate");
    a_axis_decode: assert property ((interface_select_i && $stable(axis_choice_i)) [*5] |->
        axis_en_o == axis_exp && scan_o == (axis_choice_i == 2'h0))
        else $error("axis decode wrong");
    a_gain_boost: assert property (
        (interface_select_i && $stable({gain_sel_i, range_boost_i})) [*5] |->
        gain_o == gain_sel_i && boost_o == range_boost_i)
        else $error("range decode wrong");
    a_power_flip: assert property (
        (interface_select_i && $stable({low_power_i, polarity_flip_i})) [*5] |->
        low_power_o == low_power_i && bias_flip_o == polarity_flip_i)
        else $error("power or flip decode wrong");
    a_digital_default: assert property ((!interface_select_i) [*5] |->
        gain_o == 2'h0 && !boost_o && axis_en_o == 3'h7)
        else $error("pin options applied in digital mode");
    c_frame: cover property ($fell(cs_n_i));
    c_ready: cover property ($rose(sample_ready_flag_o));
    c_hold: cover property ($fell(conv_run_o));
endmodule
bind hall_ctrl hall_ctrl_chk hall_ctrl_chk_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .interface_select_i(interface_select_i),
    .gain_sel_i(gain_sel_i), .axis_choice_i(axis_choice_i), .low_power_i(low_power_i),
    .polarity_flip_i(polarity_flip_i), .range_boost_i(range_boost_i),
    .conv_rate_sel_i(conv_rate_sel_i), .conv_hold_i(conv_hold_i), .cs_n_i(cs_n_i),
    .miso_oe_o(miso_oe_o), .sample_ready_flag_o(sample_ready_flag_o), .gain_o(gain_o),
    .boost_o(boost_o), .axis_en_o(axis_en_o), .scan_o(scan_o), .low_power_o(low_power_o),
    .bias_flip_o(bias_flip_o), .out_bits_o(out_bits_o), .conv_run_o(conv_run_o),
    .conv_strobe_o(conv_strobe_o)
);
`default_nettype wire

// ---- tb/spi_master_model.sv ----
// Behavioural SPI mode 0 master that reads the sensor and sends it words
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
    output var logic sclk_o, // Serial clock
    output var logic cs_n_o, // Select, active low
    output var logic mosi_o, // Master data
    input  wire logic miso_i // Resolved slave data
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Clock only moves inside a frame; gap sets how slow the next word comes
    task automatic xfer(input logic [15:0] tx, input int gap, output logic [15:0] rx);
        int i;
        cs_n_o = 1'b0;
        #100;
        for (i = 15; i >= 0; i--) begin
            mosi_o = tx[i];
            #62 sclk_o = 1'b1;
            rx[i] = miso_i;
            #63 sclk_o = 1'b0;
        end
        #100 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #(gap);
    endtask
endmodule
`default_nettype wire

// ---- tb/hall_ctrl_bench.sv ----
// Self-checking bench for the Hall sensor controller and its sample FIFO
`timescale 1ns/1ns
`default_nettype none
`include "hall_ctrl_map.vh"
module hall_ctrl_bench;
    logic             core_clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    logic             isel = 1'b0, lp = 1'b0, pf = 1'b0, rb = 1'b0, hold = 1'b0;
    logic [1:0]       gsel = 2'h0, axis = 2'h0, rate = 2'h0, chan = 2'h0, mux_prev;
    logic [15:0]      adc_x = 16'h0, adc_y = 16'h0, adc_z = 16'h0, adc_t = 16'h0, rd, wd;
    wire logic        sclk, cs_n, mosi, miso, miso_oe, flag, rx_valid, boost, scan;
    wire logic        lp_o, flip, run;
    wire logic [15:0] rx_word;
    wire logic [1:0]  gain, mux_axis;
    wire logic [2:0]  axis_en;
    wire logic [4:0]  bits;
    wire logic [3:0]  strobe;
    wire logic        miso_line = miso_oe ? miso : 1'bz;
    int               errors = 0, check_count = 0, cycles = 0, rx_cnt = 0, i, n;
    int unsigned      seed;
    hall_ctrl hall_ctrl_inst (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
        .interface_select_i(isel), .gain_sel_i(gsel), .axis_choice_i(axis),
        .low_power_i(lp), .polarity_flip_i(pf), .range_boost_i(rb),
        .conv_rate_sel_i(rate), .out_channel_i(chan), .ready_on_miso_i(1'b0),
        .conv_hold_i(hold), .adc_x_i(adc_x), .adc_y_i(adc_y), .adc_z_i(adc_z),
        .adc_t_i(adc_t), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_o(miso_oe), .sample_ready_flag_o(flag), .rx_word_o(rx_word),
        .rx_valid_o(rx_valid), .gain_o(gain), .boost_o(boost), .axis_en_o(axis_en),
        .scan_o(scan), .low_power_o(lp_o), .bias_flip_o(flip), .out_bits_o(bits),
        .conv_run_o(run), .conv_strobe_o(strobe), .mux_axis_o(mux_axis)
    );
    spi_master_model spi_master_model_inst (
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_line)
    );
    function automatic logic [2:0] exp_axis(input logic [1:0] c);
        return (c == 2'h0) ? 3'h7 : 3'h1 << (c - 2'h1);
    endfunction
    function automatic logic [4:0] exp_bits(input logic [1:0] r);
        return (r == 2'h0) ? `BITS_14 : (r == 2'h1) ? `BITS_15 : `BITS_16;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    always #4 core_clk_i = ~core_clk_i;
    // Longest wait is one 3 kHz conversion, so the ceiling leaves ample margin
    always @(posedge core_clk_i) begin
        cycles++;
        if (rx_valid === 1'b1)
            rx_cnt++;
        if (cycles == 80000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        seed = $urandom(99975);
        {adc_y, adc_z} = $urandom;
        adc_t = 16'($urandom);
        cyc(5);
        rst_n_i = 1'b1;
        cyc(1);
        check("miso_oe", miso_oe, 0);
        check("ready", flag, 0);
        check("bits", bits, `BITS_14);
        $display("test reset done");
        isel = 1'b1;
        for (i = 0; i < 8; i++) begin
            gsel = i[1:0];
            axis = i[2:1];
            {lp, pf, rb} = 3'($urandom);
            cyc(4);
            check("gain", gain, gsel);
            check("boost", boost, rb);
            check("axis_en", axis_en, exp_axis(axis));
            check("scan", scan, axis == 2'h0);
            check("low_power", lp_o, lp);
            check("bias_flip", flip, pf);
            if (axis != 2'h0)
                check("mux park", mux_axis, axis - 2'h1);
        end
        $display("test analog options done");
        isel = 1'b0;
        rb = 1'b1;
        gsel = 2'h3;
        cyc(4);
        check("digital gain", gain, 0);
        check("digital boost", boost, 0);
        for (i = 3; i >= 0; i--) begin
            rate = i[1:0];
            cyc(4);
            check("bits", bits, exp_bits(rate));
        end
        $display("test modes and rates done");
        adc_x = 16'($urandom);
        hold = 1'b1;
        cyc(6);
        check("run under hold", run, 0);
        hold = 1'b0;
        n = 0;
        while (strobe[0] !== 1'b1 && n < 45000) begin
            cyc(1);
            n++;
        end
        check("period", n > `CONV_3K_CYC / 2 && n < `CONV_3K_CYC + 32, 1);
        check("strobe all", strobe, 4'hF);
        check("conv run", run, 1);
        cyc(3);
        check("ready set", flag, 1);
        // Second read finds no new sample, so the last word comes again
        for (i = 0; i < 2; i++) begin
            wd = 16'($urandom);
            spi_master_model_inst.xfer(wd, 100 + 900 * i, rd);
            cyc(2);
            check("miso word", rd, adc_x >> 2);
            check("rx word", rx_word, wd);
            check("rx pulses", rx_cnt, i + 1);
            check("ready cleared", flag, 0);
            check("miso float", miso_oe, 0);
        end
        $display("test conversion and read done");
        // Scanning walks the shared amplifier over X, Y and Z in turn
        for (i = 0; i < 6; i++) begin
            mux_prev = mux_axis;
            cyc(1);
            check("mux scan", mux_axis, (mux_prev == 2'h2) ? 2'h0 : mux_prev + 2'h1);
        end
        $display("test scan done");
        end_of_test();
    end
endmodule
`default_nettype wire
